// ===== dv/bsfl_mem_model.sv
// Purpose: dram and flash words seen by the loader
// Assumes: one read or erase at a time
// Notes: delay from lat, data scrambled when idle
`timescale 1ns/1ps
module bsfl_mem_model (
    // clock and reset
    input wire logic clk_sys, reset,
    // requests
    input wire logic rd_req, fl_erase_req,
    input wire logic [31:0] rd_addr, dram0, dram1, flash0, flash1,
    input wire logic [1:0] lat,
    // answers
    output logic [31:0] rd_data,
    output logic rd_ack, fl_erase_done
);
    int cnt;
    // one counter for reads and erases; erases take longer
    always @(posedge clk_sys) begin
        rd_ack <= 1'b0;
        fl_erase_done <= 1'b0;
        rd_data <= ~rd_data; // no stale word between answers
        if (reset) begin
            cnt <= 0;
            rd_data <= 32'h0f0f_5a5a;
        end else if ((rd_req && !rd_ack) || (fl_erase_req && !fl_erase_done)) begin
            cnt <= cnt + 1;
            if (cnt >= lat + (fl_erase_req ? 6 : 0)) begin
                cnt <= 0;
                rd_ack <= rd_req;
                fl_erase_done <= fl_erase_req;
                case (rd_addr)
                    32'h8000_0000: rd_data <= dram0;
                    32'h8000_0001: rd_data <= dram1;
                    32'h00b0_0000: rd_data <= flash0;
                    32'h00b0_0001: rd_data <= flash1;
                    default: rd_data <= 32'h5a0f_f0a5;
                endcase
            end
        end
    end
endmodule // bsfl_mem_model

// ===== dv/bsfl_top_sva.sv
// Purpose: port checks on the boot loader
// Assumes: one clock, sync high reset
// Notes: bound to every bsfl_top
`timescale 1ns/1ps
module bsfl_chk #(parameter SECTORS = 8) (
    // clock, straps, panel
    input wire logic clk_sys, reset, boot_source_strap, erase_jumper, led,
    // read, erase, hand-off
    input wire logic rd_req, rd_ack, fl_erase_req, fl_erase_all, boot_go,
    input wire logic [31:0] rd_addr, rd_data, fl_erase_addr, lmi_ctrl,
    input wire logic [2:0] boot_src,
    // comm ports
    input wire logic [5:0] cp_ready
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////
    property p_first; $fell(reset) && !boot_source_strap && !erase_jumper
        |-> ##[0:3] rd_req && rd_addr == 32'h8000_0000; endproperty
    a_first: assert property (p_first) else $error("no dram read");
    property p_hold; rd_req && !rd_ack |=> rd_req && $stable(rd_addr); endproperty
    a_hold: assert property (p_hold) else $error("read dropped");
    property p_dflag; rd_ack && rd_addr == 32'h8000_0000 && rd_data == 32'ha55a_5aa5
        |-> ##[1:2] rd_req && rd_addr == 32'h8000_0001; endproperty
    a_dflag: assert property (p_dflag) else $error("no dram word1");
    property p_block; rd_ack && rd_addr == 32'h8000_0000 && rd_data == 32'hc33c_3cc3
        |-> ##[1:3] lmi_ctrl == 32'h3def_0000 && !boot_go; endproperty
    a_block: assert property (p_block) else $error("block ignored");
    property p_toflash; rd_ack && rd_addr == 32'h8000_0000 && rd_data != 32'ha55a_5aa5
        && rd_data != 32'hc33c_3cc3 |-> ##[1:2] rd_req && rd_addr == 32'h00b0_0000;
    endproperty
    a_toflash: assert property (p_toflash) else $error("no flash read");
    property p_fboot; rd_ack && rd_addr == 32'h00b0_0001
        |-> ##[1:2] boot_go && boot_src == 3'h3; endproperty
    a_fboot: assert property (p_fboot) else $error("no flash boot");
    property p_sect; fl_erase_req && !fl_erase_all |-> fl_erase_addr[15:0] == 16'h0
        && fl_erase_addr[31:19] == 13'h0016 && fl_erase_addr[18:16] < SECTORS; endproperty
    a_sect: assert property (p_sect) else $error("bad sector address");
    property p_elit; fl_erase_req && fl_erase_all
        |-> led && fl_erase_addr == 32'h00b0_0000; endproperty
    a_elit: assert property (p_elit) else $error("led not lit");
    property p_comm; (|cp_ready) |-> $onehot(cp_ready) && boot_src == 3'h4; endproperty
    a_comm: assert property (p_comm) else $error("port not locked");
endmodule // bsfl_chk
bind bsfl_top bsfl_chk #(.SECTORS(SECTORS)) u_chk (.*);

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the boot loader
// Assumes: 4 ns clock, blink 8, two sectors
// Notes: memory side from bsfl_mem_model
`timescale 1ns/1ps
module tb_top;
    localparam int SECT = 2;
    localparam logic [31:0] FLAG = 32'ha55a_5aa5, BLOCK = 32'hc33c_3cc3;
    localparam logic [31:0] ROMW = 32'h3def_0000;
    logic clk_sys = 0, reset = 1, boot_source_strap = 0, erase_jumper = 0, ld_ready = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, d0 = 0, d1 = 0, f0 = 0, f1 = 0, ea;
    logic [5:0] cp_valid = 0;
    logic [191:0] cp_data = 0;
    logic [1:0] lat = 0;
    logic [15:0] lf = 16'd89;
    wire led, ld_valid, rd_req, rd_ack, fl_erase_req, fl_erase_all, fl_erase_done, boot_go;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [2:0] boot_src;
    wire [5:0] cp_ready;
    wire [31:0] ld_data, rd_addr, rd_data, fl_erase_addr, boot_addr, lmi_ctrl, s_axi_rdata;
    int errors = 0, tests_run = 0;
    logic [31:0] q[$];
    ////////////////////////////////////////////////////////////////////
    bsfl_top #(.SECTORS(SECT), .BLINK_HALF(8)) u_dut (.*, .s_axi_wstrb(4'hf));
    bsfl_mem_model u_mem (.clk_sys, .reset, .rd_req, .fl_erase_req, .rd_addr, .dram0(d0),
        .dram1(d1), .flash0(f0), .flash1(f1), .lat, .rd_data, .rd_ack, .fl_erase_done);
    initial forever #2 clk_sys = ~clk_sys;
    initial begin #200000; errors++; results; end
    ////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tk; @(posedge clk_sys) #1; endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        chk(s_axi_bresp, er, "bresp");
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk_sys);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        chk(s_axi_rresp, er, "rresp");
        chk(s_axi_rdata, ed, "rdata");
    endtask
    // reset, then compare hand-off with model
    task automatic boot(input logic [31:0] a0, a1, b0, b1, input logic jmp);
        logic [2:0] es;
        d0 <= a0; d1 <= a1; f0 <= b0; f1 <= b1; erase_jumper <= jmp;
        lf = nx(lf); lat <= lf[1:0];
        reset <= 1; repeat (2) @(posedge clk_sys); reset <= 0;
        if (jmp) begin
            repeat (20) if (fl_erase_req !== 1'b1) tk;
            chk(fl_erase_all, 1, "erase all");
            chk(led, 1, "led lit");
        end
        es = (a0 == FLAG) ? 3'h2 : (a0 != BLOCK && b0 == FLAG) ? 3'h3 : 3'h1;
        repeat (100) if (boot_go !== 1'b1 && lmi_ctrl !== ROMW) tk;
        chk(boot_src, es, "src");
        if (es == 3'h1) chk(lmi_ctrl, ROMW, "rom lmi");
        else begin
            chk(boot_addr, es == 3'h2 ? a1 : b1, "addr");
            chk(lmi_ctrl, 0, "lmi");
        end
    endtask
    task results;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (14) @(posedge clk_sys);
        boot(FLAG, {lf, ~lf}, 0, 0, 0);
        boot(BLOCK, 0, FLAG, 32'h00b0_0008, 0);
        boot({lf, lf}, 0, FLAG, 32'h00b0_0008, 0);
        boot({~lf, lf}, 0, ~FLAG, 0, 1);
        erase_jumper <= 0;
        ea = 0;
        for (int s = 0; s < 4; s++) begin
            axi_wr(8'h00, 32'(s * 16 + 2), 2'h0);
            repeat (3) tk;
            chk(fl_erase_req, s < SECT, "sector req");
            if (s < SECT) begin
                ea = 32'h00b0_0000 + s * 32'h0001_0000;
                chk(fl_erase_addr, ea, "sector addr");
            end
            while (fl_erase_req === 1'b1) tk;
            axi_rd(8'h10, ea, 2'h0);
        end
        axi_wr(8'h04, 0, 2'h2);
        axi_rd(8'h20, 0, 2'h2);
        axi_rd(8'h0c, ROMW, 2'h0);
        // comm boot: two ports offer, lowest wins
        boot_source_strap <= 1; reset <= 1;
        repeat (2) @(posedge clk_sys);
        reset <= 0;
        repeat (5) @(posedge clk_sys);
        cp_valid <= 6'b101000;
        cp_data[96+:32] <= 32'h0;
        repeat (6) if (boot_go !== 1'b1) tk;
        chk(boot_src, 4, "comm src");
        repeat (80) begin
            @(posedge clk_sys);
            lf = nx(lf);
            if (cp_ready[3] && cp_valid[3]) begin
                q.push_back(cp_data[96+:32]);
                cp_data[96+:32] <= {lf, ~lf};
            end
            if (ld_valid && ld_ready) chk(ld_data, q.pop_front(), "load");
            ld_ready <= lf[3];
        end
        results;
    end
endmodule // tb_top

// ===== hdl/bsfl_flash_decode.v
// Purpose: flash window decode and sector start address
// Assumes: sectors are 64k words (one bus address per word) and contiguous from the flash base
// Notes:   sector count is a parameter for the small and large options
`timescale 1ns/1ps
`include "bsfl_map.vh"

module bsfl_flash_decode #(
    parameter SECTORS = `BSFL_FLASH_SECTORS
) (
    // sector query
    input  wire [`BSFL_SECTOR_BITS-1:0] sector,
    // results
    output wire                         sector_ok,
    output wire [31:0]                  sector_base
);

    // out-of-range sectors are reported, the address is still formed
    assign sector_ok   = ({29'h0, sector} < SECTORS);
    assign sector_base = `BSFL_FLASH_BASE
                       | ({29'h0, sector} << `BSFL_SECTOR_SHIFT);

endmodule // bsfl_flash_decode

// ===== hdl/bsfl_top.v
// Purpose: boot source sequencer and flash erase control
// Assumes: inputs synchronous to clk_sys, memory read port answers with ack
// Notes:   registers over axi4-lite, one read and one write at a time
`timescale 1ns/1ps
`include "bsfl_map.vh"

module bsfl_top #(
    parameter SECTORS    = `BSFL_FLASH_SECTORS,
    parameter BLINK_HALF = `BSFL_BLINK_HALF_CYC
) (
    // clock and reset
    input  wire                                 clk_sys,
    input  wire                                 reset,
    // straps and panel
    input  wire                                 boot_source_strap,
    input  wire                                 erase_jumper,
    output reg                                  led,
    // comm ports
    input  wire [`BSFL_COMM_PORTS-1:0]          cp_valid,
    input  wire [`BSFL_COMM_PORTS*32-1:0]       cp_data,
    output wire [`BSFL_COMM_PORTS-1:0]          cp_ready,
    // load stream from the chosen comm port
    output reg                                  ld_valid,
    output reg  [31:0]                          ld_data,
    input  wire                                 ld_ready,
    // local bus word read (dram and flash)
    output wire                                 rd_req,
    output reg  [31:0]                          rd_addr,
    input  wire [31:0]                          rd_data,
    input  wire                                 rd_ack,
    // flash erase port
    output wire                                 fl_erase_req,
    output reg                                  fl_erase_all,
    output reg  [31:0]                          fl_erase_addr,
    input  wire                                 fl_erase_done,
    // boot hand-off
    output reg                                  boot_go,
    output reg  [2:0]                           boot_src,
    output reg  [31:0]                          boot_addr,
    output reg  [31:0]                          lmi_ctrl,
    // axi4-lite slave
    input  wire [7:0]                           s_axi_awaddr,
    input  wire                                 s_axi_awvalid,
    output wire                                 s_axi_awready,
    input  wire [31:0]                          s_axi_wdata,
    input  wire [3:0]                           s_axi_wstrb,
    input  wire                                 s_axi_wvalid,
    output wire                                 s_axi_wready,
    output reg  [1:0]                           s_axi_bresp,
    output reg                                  s_axi_bvalid,
    input  wire                                 s_axi_bready,
    input  wire [7:0]                           s_axi_araddr,
    input  wire                                 s_axi_arvalid,
    output wire                                 s_axi_arready,
    output reg  [31:0]                          s_axi_rdata,
    output reg  [1:0]                           s_axi_rresp,
    output reg                                  s_axi_rvalid,
    input  wire                                 s_axi_rready
);

    // sequencer states
    localparam [3:0] ST_START     = 4'h0;
    localparam [3:0] ST_ERASE_ALL = 4'h1;
    localparam [3:0] ST_DRAM0     = 4'h2;
    localparam [3:0] ST_DRAM1     = 4'h3;
    localparam [3:0] ST_FLASH0    = 4'h4;
    localparam [3:0] ST_FLASH1    = 4'h5;
    localparam [3:0] ST_COMM_WAIT = 4'h6;
    localparam [3:0] ST_COMM_LOAD = 4'h7;
    localparam [3:0] ST_BOOTED    = 4'h8;
    localparam [3:0] ST_ROM       = 4'h9;
    localparam [3:0] ST_SECT_ERA  = 4'ha;

    reg  [3:0]                  state;
    reg                         erase_armed;
    reg                         erase_err;
    reg  [`BSFL_PORT_BITS-1:0]  port_sel;
    reg  [31:0]                 blink_cnt;
    reg                         restart_pulse;
    reg                         erase_pulse;
    reg  [`BSFL_SECTOR_BITS-1:0] erase_sector;
    reg                         aw_held;
    reg                         w_held;
    reg  [7:0]                  aw_addr;
    reg  [31:0]                 w_data;
    reg  [3:0]                  w_strb;
    reg  [31:0]                 next_rdata;
    reg  [1:0]                  next_rresp;
    reg                         next_found;
    reg  [`BSFL_PORT_BITS-1:0]  next_port;
    reg  [31:0]                 sel_data;
    wire                        sector_ok;
    wire [31:0]                 sector_base;
    wire                        take_word;
    wire                        busy;
    integer                     i;

    ////////////////////////////////////////////////////////////////////////
    // flash sector decode

    bsfl_flash_decode #(
        .SECTORS     (SECTORS)
    ) u_decode (
        .sector      (erase_sector),
        .sector_ok   (sector_ok),
        .sector_base (sector_base)
    );

    ////////////////////////////////////////////////////////////////////////
    // comm port selection

    // lowest index wins when several ports start in the same cycle
    always @* begin
        next_found = 1'b0;
        next_port  = {`BSFL_PORT_BITS{1'b0}};
        for (i = `BSFL_COMM_PORTS - 1; i >= 0; i = i - 1) begin
            if (cp_valid[i]) begin
                next_found = 1'b1;
                next_port  = i[`BSFL_PORT_BITS-1:0];
            end
        end
    end

    // data of the locked port only
    always @* begin
        sel_data = 32'h0;
        for (i = 0; i < `BSFL_COMM_PORTS; i = i + 1) begin
            if (port_sel == i[`BSFL_PORT_BITS-1:0]) begin
                sel_data = cp_data[i*32 +: 32];
            end
        end
    end

    // other ports are never drained once one is locked
    assign take_word = (state == ST_COMM_LOAD) && (!ld_valid || ld_ready);
    genvar g;
    generate
        for (g = 0; g < `BSFL_COMM_PORTS; g = g + 1) begin : g_ready
            assign cp_ready[g] = take_word && (port_sel == g);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // handshake outputs

    assign rd_req = (state == ST_DRAM0) || (state == ST_DRAM1)
                 || (state == ST_FLASH0) || (state == ST_FLASH1);
    assign fl_erase_req = (state == ST_ERASE_ALL) || (state == ST_SECT_ERA);
    assign busy = (state != ST_ROM) && (state != ST_BOOTED)
               && (state != ST_COMM_LOAD);

    ////////////////////////////////////////////////////////////////////////
    // boot sequencer

    always @(posedge clk_sys) begin
        if (reset) begin
            state         <= ST_START;
            erase_armed   <= 1'b0;
            erase_err     <= 1'b0;
            port_sel      <= {`BSFL_PORT_BITS{1'b0}};
            rd_addr       <= 32'h0;
            fl_erase_all  <= 1'b0;
            fl_erase_addr <= 32'h0;
            boot_go       <= 1'b0;
            boot_src      <= `BSFL_SRC_NONE;
            boot_addr     <= 32'h0;
            lmi_ctrl      <= `BSFL_LMI_RESET;
            ld_valid      <= 1'b0;
            ld_data       <= 32'h0;
        end else begin
            boot_go <= 1'b0;
            if (ld_valid && ld_ready) begin
                ld_valid <= 1'b0;
            end
            case (state)
                // jumper is sampled on the first edge after reset release
                ST_START: begin
                    boot_src <= `BSFL_SRC_NONE;
                    if (erase_jumper && !erase_armed) begin
                        erase_armed   <= 1'b1;
                        fl_erase_all  <= 1'b1;
                        fl_erase_addr <= `BSFL_FLASH_BASE;
                        state         <= ST_ERASE_ALL;
                    end else if (boot_source_strap == `BSFL_STRAP_COMM) begin
                        state <= ST_COMM_WAIT;
                    end else begin
                        rd_addr <= `BSFL_DRAM_WORD0;
                        state   <= ST_DRAM0;
                    end
                end
                ST_ERASE_ALL: begin
                    if (fl_erase_done) begin
                        fl_erase_all <= 1'b0;
                        state        <= ST_START;
                    end
                end
                // dram flag is looked at before anything in flash
                ST_DRAM0: begin
                    if (rd_ack) begin
                        if (rd_data == `BSFL_BOOT_FLAG) begin
                            rd_addr <= `BSFL_DRAM_WORD1;
                            state   <= ST_DRAM1;
                        end else if (rd_data == `BSFL_BLOCK_CODE) begin
                            lmi_ctrl <= `BSFL_LMI_EXPANSION;
                            boot_src <= `BSFL_SRC_ROM;
                            state    <= ST_ROM;
                        end else begin
                            rd_addr <= `BSFL_FLASH_BASE;
                            state   <= ST_FLASH0;
                        end
                    end
                end
                ST_DRAM1: begin
                    if (rd_ack) begin
                        boot_addr <= rd_data;
                        boot_src  <= `BSFL_SRC_DRAM;
                        boot_go   <= 1'b1;
                        state     <= ST_BOOTED;
                    end
                end
                ST_FLASH0: begin
                    if (rd_ack) begin
                        if (rd_data == `BSFL_BOOT_FLAG) begin
                            rd_addr <= `BSFL_FLASH_WORD1;
                            state   <= ST_FLASH1;
                        end else begin
                            lmi_ctrl <= `BSFL_LMI_EXPANSION;
                            boot_src <= `BSFL_SRC_ROM;
                            state    <= ST_ROM;
                        end
                    end
                end
                // second image word holds the code start address
                ST_FLASH1: begin
                    if (rd_ack) begin
                        boot_addr <= rd_data;
                        boot_src  <= `BSFL_SRC_FLASH;
                        boot_go   <= 1'b1;
                        state     <= ST_BOOTED;
                    end
                end
                ST_COMM_WAIT: begin
                    if (next_found) begin
                        port_sel  <= next_port;
                        boot_src  <= `BSFL_SRC_COMM;
                        boot_addr <= 32'h0;
                        boot_go   <= 1'b1;
                        state     <= ST_COMM_LOAD;
                    end
                end
                // whole program comes from the locked port until restart
                ST_COMM_LOAD: begin
                    if (take_word && cp_valid[port_sel]) begin
                        ld_valid <= 1'b1;
                        ld_data  <= sel_data;
                    end
                end
                ST_SECT_ERA: begin
                    if (fl_erase_done) begin
                        state <= ST_ROM;
                    end
                end
                default: begin
                    state <= state;
                end
            endcase
            // sector erase only from the settled rom program
            if (erase_pulse && (state == ST_ROM)) begin
                if (sector_ok) begin
                    erase_err     <= 1'b0;
                    fl_erase_addr <= sector_base;
                    state         <= ST_SECT_ERA;
                end else begin
                    erase_err <= 1'b1;
                end
            end
            if (restart_pulse && !fl_erase_req) begin
                ld_valid <= 1'b0;
                state    <= ST_START;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // panel led: lit until the rom program runs, blinking there

    always @(posedge clk_sys) begin
        if (reset) begin
            led       <= 1'b1;
            blink_cnt <= 32'h0;
        end else if (state != ST_ROM) begin
            led       <= 1'b1;
            blink_cnt <= 32'h0;
        end else if (blink_cnt == BLINK_HALF - 1) begin
            led       <= ~led;
            blink_cnt <= 32'h0;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write side

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    always @(posedge clk_sys) begin
        if (reset) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h0;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BSFL_RESP_OKAY;
            restart_pulse <= 1'b0;
            erase_pulse   <= 1'b0;
            erase_sector  <= {`BSFL_SECTOR_BITS{1'b0}};
        end else begin
            restart_pulse <= 1'b0;
            erase_pulse   <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr == `BSFL_REG_CTRL) begin
                    s_axi_bresp <= `BSFL_RESP_OKAY;
                    if (w_strb[0]) begin
                        restart_pulse <= w_data[`BSFL_CTRL_RESTART];
                        erase_pulse   <= w_data[`BSFL_CTRL_ERASE];
                        erase_sector  <= w_data[`BSFL_CTRL_SECT_LO +:
                                                `BSFL_SECTOR_BITS];
                    end
                end else begin
                    s_axi_bresp <= `BSFL_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read side

    assign s_axi_arready = !s_axi_rvalid;

    always @* begin
        next_rdata = 32'h0;
        next_rresp = `BSFL_RESP_OKAY;
        case (s_axi_araddr)
            `BSFL_REG_CTRL: begin
                next_rdata[`BSFL_CTRL_SECT_LO +: `BSFL_SECTOR_BITS] = erase_sector;
            end
            `BSFL_REG_STATUS: begin
                next_rdata[`BSFL_ST_STATE_LO +: 4] = state;
                next_rdata[`BSFL_ST_SRC_LO +: 3]   = boot_src;
                next_rdata[`BSFL_ST_PORT_LO +: `BSFL_PORT_BITS] = port_sel;
                next_rdata[`BSFL_ST_BUSY]      = busy;
                next_rdata[`BSFL_ST_ERASE_ERR] = erase_err;
                next_rdata[`BSFL_ST_LED]       = led;
            end
            `BSFL_REG_BOOT_ADDR: begin
                next_rdata = boot_addr;
            end
            `BSFL_REG_LMI: begin
                next_rdata = lmi_ctrl;
            end
            `BSFL_REG_ERASE_ADDR: begin
                next_rdata = fl_erase_addr;
            end
            default: begin
                next_rresp = `BSFL_RESP_SLVERR;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `BSFL_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // bsfl_top

// ===== shared/bsfl_map.vh
// Purpose: constants for the boot source and flash loader
// Assumes: 250 MHz system clock, 32-bit local bus addresses
// Notes:   addresses, codes and register fields are named here; state codes stay in bsfl_top
`ifndef BSFL_MAP_VH
`define BSFL_MAP_VH

// shared dram and flash addresses
`define BSFL_DRAM_WORD0     32'h8000_0000
`define BSFL_DRAM_WORD1     32'h8000_0001
`define BSFL_FLASH_BASE     32'h00b0_0000
`define BSFL_FLASH_WORD1    32'h00b0_0001
`define BSFL_SECTOR_SHIFT   16
`define BSFL_SECTOR_BITS    3
`define BSFL_FLASH_SECTORS  8

// data codes found in the first words
`define BSFL_BOOT_FLAG      32'ha55a_5aa5
`define BSFL_BLOCK_CODE     32'hc33c_3cc3

// local memory interface control word
`define BSFL_LMI_RESET      32'h0000_0000
`define BSFL_LMI_EXPANSION  32'h3def_0000

// boot source codes
`define BSFL_SRC_NONE       3'h0
`define BSFL_SRC_ROM        3'h1
`define BSFL_SRC_DRAM       3'h2
`define BSFL_SRC_FLASH      3'h3
`define BSFL_SRC_COMM       3'h4

// strap values
`define BSFL_STRAP_ROM      1'b0
`define BSFL_STRAP_COMM     1'b1

// comm ports
`define BSFL_COMM_PORTS     6
`define BSFL_PORT_BITS      3

// register byte offsets
`define BSFL_REG_CTRL       8'h00
`define BSFL_REG_STATUS     8'h04
`define BSFL_REG_BOOT_ADDR  8'h08
`define BSFL_REG_LMI        8'h0c
`define BSFL_REG_ERASE_ADDR 8'h10

// control register fields
`define BSFL_CTRL_RESTART   0
`define BSFL_CTRL_ERASE     1
`define BSFL_CTRL_SECT_LO   4

// status register fields
`define BSFL_ST_STATE_LO    0
`define BSFL_ST_SRC_LO      8
`define BSFL_ST_PORT_LO     12
`define BSFL_ST_BUSY        16
`define BSFL_ST_ERASE_ERR   17
`define BSFL_ST_LED         18

// axi responses
`define BSFL_RESP_OKAY      2'h0
`define BSFL_RESP_SLVERR    2'h2

// timing: led half period for about 5 Hz blink
`define BSFL_CLK_KHZ        250000
`define BSFL_BLINK_HALF_MS  100
`define BSFL_BLINK_HALF_CYC (`BSFL_BLINK_HALF_MS * `BSFL_CLK_KHZ)

`endif
